// ### core/dfl_fault_latch.sv
// drive fault mask, latch and output-disable logic
//
// Contract
// - mask bit set: event latches a fault
// - mask bit clear: event-specific recovery, no latch
// - latched faults cleared only via status register
// - mask bit 0 read-only, always set
// - corrupt flash at startup: disabled, faulted
// - bit 1 fixed set; self-test fail disables
// - short unmasked: disable 100 ms, re-enable
// - drive overtemp unmasked: re-enable when cool
// - motor overtemp unmasked: re-enable when inactive
// - overvoltage unmasked: re-enable when normal
// - undervoltage unmasked: re-enable when normal
// - feedback masked: any feedback event latches
// - feedback event from supply, disconnect, levels
// - phasing unmasked: re-enable when error removed
// - following error: latch+disable, else abort
// - current limiting masked: latch a fault
`timescale 1ns/1ps

module dfl_fault_latch
  import dfl_pkg::*;
#(
  parameter int SHORT_HOLD_CYC = DFL_SHORT_HOLD_CYC
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  // monitor event inputs (asynchronous levels)
  input  wire logic        FLASH_CRC_BAD,
  input  wire logic        SELF_TEST_FAIL,
  input  wire logic        SHORT_DETECT,
  input  wire logic        DRIVE_OVER_TEMP,
  input  wire logic        MOTOR_OVER_TEMP,
  input  wire logic        BUS_OVER_VOLT,
  input  wire logic        BUS_UNDER_VOLT,
  input  wire logic        FB_SUPPLY_OVERCURR,
  input  wire logic        FB_SENSOR_OPEN,
  input  wire logic        FB_LEVEL_BAD,
  input  wire logic        PHASING_ERROR,
  input  wire logic        FOLLOWING_ERROR,
  input  wire logic        CURRENT_LIMITING,
  // parameter access port
  input  wire logic        PAR_WR,
  input  wire logic [11:0] PAR_ADDR,
  input  wire logic [31:0] PAR_WDATA,
  output logic      [31:0] PAR_RDATA,
  // drive control outputs
  output logic             OUTPUT_DISABLE,
  output logic             MOVE_ABORT,
  output logic             FAULT_LATCHED
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [DFL_NUM_RAW-1:0]    raw_in;
  logic [DFL_NUM_RAW-1:0]    sync1_r;
  logic [DFL_NUM_RAW-1:0]    sync2_r;
  logic [DFL_NUM_EVENTS-1:0] ev;
  logic                      fb_any;
  logic [DFL_NUM_EVENTS-1:0] mask_r;
  logic [DFL_NUM_EVENTS-1:0] mask_eff;
  logic [DFL_NUM_EVENTS-1:0] latched_r;
  logic [DFL_NUM_EVENTS-1:0] latched_nxt;
  logic [DFL_NUM_EVENTS-1:0] clr_bits;
  logic                      clr_wr;
  logic                      mask_wr;
  logic                      short_prev_r;
  logic                      short_rise;
  dfl_short_e                sh_state_r;
  dfl_short_e                sh_state_nxt;
  logic [DFL_CNT_W-1:0]      sh_cnt_r;
  logic                      sh_hold_nxt;
  logic                      recover_active;
  logic                      dis_nxt;
  logic                      out_dis_r;
  logic                      abort_r;
  logic                      latched_any_r;
  logic [31:0]               rdata_r;

  localparam logic [DFL_CNT_W-1:0] HOLD_LOAD = DFL_CNT_W'(SHORT_HOLD_CYC - 1);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  assign raw_in = {CURRENT_LIMITING, FOLLOWING_ERROR, PHASING_ERROR,
                   FB_LEVEL_BAD, FB_SENSOR_OPEN, FB_SUPPLY_OVERCURR,
                   BUS_UNDER_VOLT, BUS_OVER_VOLT, MOTOR_OVER_TEMP,
                   DRIVE_OVER_TEMP, SHORT_DETECT, SELF_TEST_FAIL, FLASH_CRC_BAD};

  // monitors are off-domain; only the second stage is ever read
  genvar gi;
  generate
    for (gi = 0; gi < DFL_NUM_RAW; gi++) begin : g_sync
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // event vector
  // ---------------------------------------------------------------
  // three feedback sources sit on raw lines 7..9
  assign fb_any = sync2_r[9] | sync2_r[8] | sync2_r[7];

  // raw lines 0..6 map straight onto event bits; lines 10..12 shift down by two
  assign ev = {sync2_r[12], sync2_r[11], sync2_r[10], fb_any,
               sync2_r[DFL_BIT_UNDER_VOLT:DFL_BIT_FLASH_CRC]};

  // ---------------------------------------------------------------
  // fault mask register
  // ---------------------------------------------------------------
  assign mask_wr = PAR_WR && (PAR_ADDR == DFL_ADDR_FAULT_MASK);

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_r <= DFL_MASK_RESET;
    end else if (mask_wr) begin
      mask_r <= (PAR_WDATA[DFL_NUM_EVENTS-1:0] & DFL_MASK_WRITABLE) | DFL_MASK_FORCED;
    end
  end

  // integrity and self-test bits can never be masked off
  assign mask_eff = mask_r | DFL_MASK_FORCED;

  // ---------------------------------------------------------------
  // latched faults
  // ---------------------------------------------------------------
  assign clr_wr   = PAR_WR && (PAR_ADDR == DFL_ADDR_LATCH_STATUS);
  assign clr_bits = clr_wr ? PAR_WDATA[DFL_NUM_EVENTS-1:0] : '0;

  // set wins over clear so an event in the clearing cycle survives
  assign latched_nxt = (latched_r & ~clr_bits) | (ev & mask_eff);

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      latched_r <= '0;
    end else begin
      latched_r <= latched_nxt;
    end
  end

  // ---------------------------------------------------------------
  // short-circuit hold timer (unmasked case)
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      short_prev_r <= 1'b0;
    end else begin
      short_prev_r <= ev[DFL_BIT_SHORT];
    end
  end

  assign short_rise = ev[DFL_BIT_SHORT] && !short_prev_r && !mask_eff[DFL_BIT_SHORT];

  always_comb begin
    sh_state_nxt = sh_state_r;
    case (sh_state_r)
      DFL_SH_IDLE: begin
        if (short_rise) begin
          sh_state_nxt = DFL_SH_HOLD;
        end
      end
      DFL_SH_HOLD: begin
        if (!short_rise && sh_cnt_r == '0) begin
          sh_state_nxt = DFL_SH_IDLE;
        end
      end
      default: begin
        sh_state_nxt = DFL_SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sh_state_r <= DFL_SH_IDLE;
    end else begin
      sh_state_r <= sh_state_nxt;
    end
  end

  // a new short restarts the full hold time
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sh_cnt_r <= '0;
    end else if (short_rise) begin
      sh_cnt_r <= HOLD_LOAD;
    end else if (sh_cnt_r != '0) begin
      sh_cnt_r <= sh_cnt_r - 1'b1;
    end
  end

  assign sh_hold_nxt = (sh_state_nxt == DFL_SH_HOLD);

  // ---------------------------------------------------------------
  // output disable and move abort
  // ---------------------------------------------------------------
  // unmasked temperature, voltage and phasing events disable only while present
  assign recover_active = |(ev & ~mask_eff & DFL_RECOVER_BITS);

  assign dis_nxt = (|latched_nxt) | sh_hold_nxt | recover_active;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_dis_r     <= 1'b1;
      latched_any_r <= 1'b0;
    end else begin
      out_dis_r     <= dis_nxt;
      latched_any_r <= |latched_nxt;
    end
  end

  // unmasked following error aborts the move, drive stays enabled
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= ev[DFL_BIT_FOLLOW] && !mask_eff[DFL_BIT_FOLLOW];
    end
  end

  assign OUTPUT_DISABLE = out_dis_r;
  assign MOVE_ABORT     = abort_r;
  assign FAULT_LATCHED  = latched_any_r;

  // ---------------------------------------------------------------
  // read path, one cycle latency
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= '0;
    end else begin
      case (PAR_ADDR)
        DFL_ADDR_FAULT_MASK:   rdata_r <= {21'h000000, mask_eff};
        DFL_ADDR_LATCH_STATUS: rdata_r <= {21'h000000, latched_r};
        default:               rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign PAR_RDATA = rdata_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dfl_cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_short_start;
    short_rise;
  endsequence

  sequence s_short_held;
    OUTPUT_DISABLE [*8];
  endsequence

  chk_mask_fixed_bits: assert property (mask_eff[1:0] == 2'b11)
    else $error("fixed mask bits not set");

  chk_masked_event_latch: assert property (
    |(ev & mask_eff) |=> FAULT_LATCHED && OUTPUT_DISABLE)
    else $error("masked event did not latch");

  chk_unmasked_no_latch: assert property (
    !latched_r[DFL_BIT_DRV_TEMP] && !(ev[DFL_BIT_DRV_TEMP] && mask_eff[DFL_BIT_DRV_TEMP])
    |=> !latched_r[DFL_BIT_DRV_TEMP])
    else $error("unmasked event latched");

  chk_clear_only_status: assert property (
    (|($past(latched_r) & ~latched_r)) |-> $past(clr_wr))
    else $error("latched fault dropped without status write");

  chk_flash_disable: assert property (
    ev[DFL_BIT_FLASH_CRC] |=> OUTPUT_DISABLE && latched_r[DFL_BIT_FLASH_CRC])
    else $error("flash fault did not disable");

  chk_selftest_disable: assert property (
    ev[DFL_BIT_INT_ERROR] |=> OUTPUT_DISABLE && FAULT_LATCHED)
    else $error("self-test fault did not disable");

  chk_short_hold_time: assert property (
    s_short_start |=> s_short_held)
    else $error("short hold released early");

  chk_recover_release: assert property (
    !(|latched_nxt) && !sh_hold_nxt && !recover_active |=> !OUTPUT_DISABLE)
    else $error("drive not re-enabled after recovery");

  chk_unmasked_hold: assert property (
    recover_active |=> OUTPUT_DISABLE)
    else $error("recoverable event did not disable");

  chk_follow_abort: assert property (
    ev[DFL_BIT_FOLLOW] && !mask_eff[DFL_BIT_FOLLOW] |=> MOVE_ABORT && !latched_r[DFL_BIT_FOLLOW] ||
    $past(latched_r[DFL_BIT_FOLLOW]))
    else $error("following error abort missing");

  chk_latched_keeps_off: assert property (
    FAULT_LATCHED |-> OUTPUT_DISABLE)
    else $error("outputs enabled with latched fault");

  chk_set_beats_clear: assert property (
    clr_wr && |(ev & mask_eff) |=> |(latched_r & $past(ev & mask_eff)) ##0 FAULT_LATCHED)
    else $error("event lost in clear cycle");

  chk_motor_temp_recover: assert property (
    ev[DFL_BIT_MOT_TEMP] && !mask_eff[DFL_BIT_MOT_TEMP] && !latched_r[DFL_BIT_MOT_TEMP]
    |=> OUTPUT_DISABLE && !latched_r[DFL_BIT_MOT_TEMP])
    else $error("motor overtemp not handled as recoverable");

  chk_undervolt_recover: assert property (
    ev[DFL_BIT_UNDER_VOLT] && !mask_eff[DFL_BIT_UNDER_VOLT] && !latched_r[DFL_BIT_UNDER_VOLT]
    |=> OUTPUT_DISABLE && !latched_r[DFL_BIT_UNDER_VOLT])
    else $error("undervoltage not handled as recoverable");

  chk_phasing_recover: assert property (
    ev[DFL_BIT_PHASING] && !mask_eff[DFL_BIT_PHASING] && !latched_r[DFL_BIT_PHASING]
    |=> OUTPUT_DISABLE && !latched_r[DFL_BIT_PHASING])
    else $error("phasing error not handled as recoverable");

  chk_feedback_latch: assert property (
    ev[DFL_BIT_FEEDBACK] && mask_eff[DFL_BIT_FEEDBACK] |=> latched_r[DFL_BIT_FEEDBACK])
    else $error("feedback event did not latch");

  chk_feedback_sources: assert property (
    (sync2_r[7] || sync2_r[8] || sync2_r[9]) |-> ev[DFL_BIT_FEEDBACK])
    else $error("feedback source not reported");

  chk_curr_limit_latch: assert property (
    ev[DFL_BIT_CURR_LIMIT] && mask_eff[DFL_BIT_CURR_LIMIT]
    |=> latched_r[DFL_BIT_CURR_LIMIT] && OUTPUT_DISABLE)
    else $error("current limiting did not latch");

  chk_follow_masked: assert property (
    ev[DFL_BIT_FOLLOW] && mask_eff[DFL_BIT_FOLLOW]
    |=> latched_r[DFL_BIT_FOLLOW] && OUTPUT_DISABLE && !MOVE_ABORT)
    else $error("masked following error did not latch");

  chk_short_masked_latch: assert property (
    ev[DFL_BIT_SHORT] && mask_eff[DFL_BIT_SHORT] |=> latched_r[DFL_BIT_SHORT])
    else $error("masked short did not latch");

endmodule

// ### core/dfl_pkg.sv
// package: register map, field positions and timing for the drive fault latch block
package dfl_pkg;

  // ---------------------------------------------------------------
  // register map (parameter ids)
  // ---------------------------------------------------------------
  localparam logic [11:0] DFL_ADDR_LATCH_STATUS = 12'h0A4;
  localparam logic [11:0] DFL_ADDR_FAULT_MASK   = 12'h0A7;

  // ---------------------------------------------------------------
  // event bit positions inside the mask and status words
  // ---------------------------------------------------------------
  localparam int DFL_BIT_FLASH_CRC  = 0;
  localparam int DFL_BIT_INT_ERROR  = 1;
  localparam int DFL_BIT_SHORT      = 2;
  localparam int DFL_BIT_DRV_TEMP   = 3;
  localparam int DFL_BIT_MOT_TEMP   = 4;
  localparam int DFL_BIT_OVER_VOLT  = 5;
  localparam int DFL_BIT_UNDER_VOLT = 6;
  localparam int DFL_BIT_FEEDBACK   = 7;
  localparam int DFL_BIT_PHASING    = 8;
  localparam int DFL_BIT_FOLLOW     = 9;
  localparam int DFL_BIT_CURR_LIMIT = 10;
  localparam int DFL_NUM_EVENTS     = 11;
  localparam int DFL_NUM_RAW        = 13;

  // ---------------------------------------------------------------
  // fixed and reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] DFL_MASK_FORCED   = 11'h003;
  localparam logic [10:0] DFL_MASK_WRITABLE = 11'h7FC;
  localparam logic [10:0] DFL_MASK_RESET    = 11'h003;
  localparam logic [10:0] DFL_RECOVER_BITS  = 11'h178;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int DFL_CLK_HZ        = 20_000_000;
  localparam int DFL_SHORT_HOLD_MS = 100;
  localparam int DFL_SHORT_HOLD_CYC = DFL_SHORT_HOLD_MS * (DFL_CLK_HZ / 1000);
  localparam int DFL_CNT_W         = 22;

  typedef enum logic [1:0] {
    DFL_SH_IDLE = 2'b01,
    DFL_SH_HOLD = 2'b10
  } dfl_short_e;

endpackage

// ### test/dfl_monitor_model.sv
// model of the drive monitors that feed event levels to the fault block
`timescale 1ns/1ps

module dfl_monitor_model (
  // requested monitor levels
  input  wire logic [12:0] ev_req,
  // event lines toward the fault block
  output logic      [12:0] ev_line
);
  // ---------------------------------------------------------------
  // event lines
  // ---------------------------------------------------------------
  // three feedback sources stay separate lines
  assign ev_line = ev_req;
endmodule

// ### test/dfl_fault_latch_test.sv
// testbench: mask register, fault latching, recovery and clearing
`timescale 1ns/1ps

module dfl_fault_latch_test
  import dfl_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int HOLD = 30;
  logic        ref_clk;
  logic        reset_n;
  logic [12:0] ev;
  logic [12:0] pin;
  logic        par_wr;
  logic [11:0] par_addr;
  logic [31:0] par_wdata;
  logic [31:0] par_rdata;
  logic        out_dis;
  logic        abort;
  logic        latched;
  int          err_total;
  int          cmp_count;

  dfl_monitor_model mon (.ev_req(ev), .ev_line(pin));

  dfl_fault_latch #(.SHORT_HOLD_CYC(HOLD)) uut (
    .REF_CLK(ref_clk), .RESET_N(reset_n),
    .FLASH_CRC_BAD(pin[0]), .SELF_TEST_FAIL(pin[1]),
    .SHORT_DETECT(pin[2]), .DRIVE_OVER_TEMP(pin[3]),
    .MOTOR_OVER_TEMP(pin[4]), .BUS_OVER_VOLT(pin[5]),
    .BUS_UNDER_VOLT(pin[6]), .FB_SUPPLY_OVERCURR(pin[7]),
    .FB_SENSOR_OPEN(pin[8]), .FB_LEVEL_BAD(pin[9]),
    .PHASING_ERROR(pin[10]), .FOLLOWING_ERROR(pin[11]),
    .CURRENT_LIMITING(pin[12]), .PAR_WR(par_wr),
    .PAR_ADDR(par_addr), .PAR_WDATA(par_wdata),
    .PAR_RDATA(par_rdata), .OUTPUT_DISABLE(out_dis),
    .MOVE_ABORT(abort), .FAULT_LATCHED(latched));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // outputs packed as disable, abort, latched
  task automatic chk_out(input logic [2:0] exp);
    chk(32'({out_dis, abort, latched}), 32'(exp));
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    par_wr    = 1'b1;
    par_addr  = a;
    par_wdata = d;
    step(1);
    par_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    par_addr = a;
    step(1);
    chk(par_rdata, exp);
  endtask

  // raw event line to status bit: three feedback lines share bit 7
  function automatic int bitof(input int r);
    return (r < 7) ? r : ((r < 10) ? 7 : r - 2);
  endfunction

  // raise one event, drop it, then clear whatever it latched
  task automatic ev_case(input int r, input logic [2:0] on, input logic lat,
                         input logic [31:0] m);
    ev[r] = 1'b1;
    step(3);
    chk_out(on);
    ev[r] = 1'b0;
    step(3);
    chk_out({lat, 1'b0, lat});
    if (lat) begin
      rd(DFL_ADDR_LATCH_STATUS, 32'h1 << bitof(r));
      wr(DFL_ADDR_FAULT_MASK, m);
      chk_out(3'b101);
      wr(DFL_ADDR_LATCH_STATUS, 32'h1 << bitof(r));
      step(1);
      chk_out(3'b000);
    end
  endtask

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    final_report();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    cmp_count = 0;
    reset_n   = 1'b0;
    ev        = 13'h0000;
    par_wr    = 1'b0;
    par_addr  = 12'h000;
    par_wdata = 32'h00000000;
    step(2);
    chk_out(3'b100);
    step(3);
    reset_n = 1'b1;
    step(1);
    chk_out(3'b000);
    rd(DFL_ADDR_FAULT_MASK, 32'h00000003);
    rd(DFL_ADDR_LATCH_STATUS, 32'h00000000);
    wr(DFL_ADDR_FAULT_MASK, 32'hFFFFFFFF);
    rd(DFL_ADDR_FAULT_MASK, 32'h000007FF);
    wr(DFL_ADDR_FAULT_MASK, 32'h00000000);
    rd(DFL_ADDR_FAULT_MASK, 32'h00000003);
    rd(12'h123, 32'h00000000);
    // unmasked: forced bits still latch, others take their own action
    for (int r = 0; r < 13; r++) begin
      if (r != 2) begin
        ev_case(r, {(r < 2) || (r inside {3, 4, 5, 6, 10}), r == 11, r < 2},
                r < 2, 32'h0);
      end
    end
    // short unmasked: timed disable, not extended by a steady level
    ev[2] = 1'b1;
    step(3);
    chk_out(3'b100);
    step(HOLD - 6);
    chk_out(3'b100);
    step(10);
    chk_out(3'b000);
    ev[2] = 1'b0;
    step(3);
    ev[2] = 1'b1;
    step(3);
    chk_out(3'b100);
    ev[2] = 1'b0;
    step(HOLD + 5);
    chk_out(3'b000);
    // every event masked: each latches and disables
    wr(DFL_ADDR_FAULT_MASK, 32'h000007FF);
    for (int r = 0; r < 13; r++) begin
      ev_case(r, 3'b101, 1'b1, 32'h000007FF);
    end
    // clear while the event is still present must not win
    ev[3] = 1'b1;
    step(3);
    wr(DFL_ADDR_LATCH_STATUS, 32'h00000008);
    step(1);
    chk_out(3'b101);
    ev[3] = 1'b0;
    step(3);
    wr(DFL_ADDR_LATCH_STATUS, 32'h00000008);
    step(1);
    chk_out(3'b000);
    final_report();
  end
endmodule
